// ---- common/sleep_ctl_pkg.sv ----
// Package: register map, control fields and timing constants for the sleep/RTC block
package sleep_ctl_pkg;
    localparam logic [11:0] OFF_COUNTER = 12'h000;
    localparam logic [11:0] OFF_MATCH_ZERO = 12'h004;
    localparam logic [11:0] OFF_MATCH_ONE = 12'h008;
    localparam logic [11:0] OFF_LOAD = 12'h00c;
    localparam logic [11:0] OFF_CONTROL = 12'h010;
    localparam logic [11:0] OFF_MASK = 12'h014;
    localparam logic [11:0] OFF_RAW = 12'h018;
    localparam logic [11:0] OFF_MASKED = 12'h01c;
    localparam logic [11:0] OFF_CLEAR = 12'h020;
    localparam logic [11:0] OFF_TRIM = 12'h024;
    localparam logic [11:0] OFF_MEM_LO = 12'h030;
    localparam logic [11:0] OFF_MEM_HI = 12'h12c;
    localparam int MEM_WORDS = 64;
    // Control fields
    localparam int CTL_COUNTER_ENABLE = 0;
    localparam int CTL_SLEEP_REQUEST = 1;
    localparam int CTL_REFERENCE_SELECT = 2;
    localparam int CTL_MATCH_WAKE_ENABLE = 3;
    localparam int CTL_PIN_WAKE_ENABLE = 4;
    localparam int CTL_LOW_BATTERY_DETECT_ENABLE = 5;
    localparam int CTL_REFERENCE_CLOCK_ENABLE = 6;
    localparam int CTL_LOW_BATTERY_ABORT = 7;
    // Event bits (mask, raw, masked, clear)
    localparam int EV_MATCH_ZERO = 0;
    localparam int EV_MATCH_ONE = 1;
    localparam int EV_LOW_BATTERY = 2;
    localparam int EV_WAKE_PIN = 3;
    localparam int EV_BITS = 4;
    // Reset values, divide constants and bus response codes
    localparam logic [31:0] RST_MATCH = 32'hffffffff;
    localparam logic [31:0] RST_LOAD = 32'hffffffff;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [14:0] RST_TRIM = 15'h7fff;
    localparam logic [14:0] NOMINAL_DIVIDE = 15'h7fff;
    localparam logic [5:0] TRIM_PERIOD_LAST = 6'h3f;
    localparam logic [6:0] CRYSTAL_DIVIDE_LAST = 7'h7f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/sleep_rtc_ctl.sv ----
// Sleep controller with seconds counter, match compare, retained memory and AXI4-Lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sleep_rtc_ctl
    import sleep_ctl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic REF_CLK_IN,
    input wire logic WAKE_N,
    input wire logic LOW_BATTERY,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic REGULATOR_OFF_N,
    output logic WAKE_RESET,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync1_nxt;
    logic [2:0] sync2_nxt;
    logic ref_prev_r;
    logic ref_prev_nxt;

    always_comb
    begin
        sync1_nxt = {LOW_BATTERY, ~WAKE_N, REF_CLK_IN};
        sync2_nxt = sync1_r;
        ref_prev_nxt = sync2_r[0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (CLK_EN)
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            ref_prev_r <= ref_prev_nxt;
        end
    end

    logic ref_rise;
    logic wake_pin;
    logic low_batt;
    assign ref_rise = sync2_r[0] & ~ref_prev_r;
    assign wake_pin = sync2_r[1];
    assign low_batt = sync2_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [31:0] counter_r, counter_nxt;
    logic [31:0] match_zero_r, match_zero_nxt;
    logic [31:0] match_one_r, match_one_nxt;
    logic [31:0] load_r, load_nxt;
    logic [7:0] control_r, control_nxt;
    logic [EV_BITS-1:0] mask_r, mask_nxt;
    logic [EV_BITS-1:0] raw_r, raw_nxt;
    logic [14:0] trim_r, trim_nxt;
    logic [14:0] prediv_r, prediv_nxt;
    logic [5:0] second_idx_r, second_idx_nxt;
    logic [6:0] xtal_div_r, xtal_div_nxt;
    logic regulator_off_n_r, regulator_off_n_nxt;
    logic wake_reset_r, wake_reset_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] mem_r [MEM_WORDS];

    // Retained state ignores system reset while the counter or pin wake is armed
    logic hold_state;
    assign hold_state = control_r[CTL_COUNTER_ENABLE] | control_r[CTL_PIN_WAKE_ENABLE];
    logic do_reset;
    assign do_reset = ~RST_N & ~hold_state;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic aw_have_r, aw_have_nxt;
    logic w_have_r, w_have_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic arready_r, arready_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;

    logic wr_go;
    logic [31:0] wr_val;
    logic wr_ok;
    logic [5:0] mem_widx;
    logic [5:0] mem_ridx;
    logic wr_mem;
    logic [31:0] rd_val;
    logic rd_ok;

    assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
    assign mem_widx = awaddr_r[7:2] - 6'h0c;
    assign mem_ridx = S_AXI_ARADDR[7:2] - 6'h0c;
    assign wr_mem = wr_go & (awaddr_r >= OFF_MEM_LO) & (awaddr_r <= OFF_MEM_HI);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
        begin
            r[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction

    // Strobed merges of the narrow registers, cut to width where used
    logic [31:0] ctl_wr;
    logic [31:0] mask_wr;
    logic [31:0] trim_wr;
    assign ctl_wr = merge({24'h000000, control_r}, wdata_r, wstrb_r);
    assign mask_wr = merge({28'h0000000, mask_r}, wdata_r, wstrb_r);
    assign trim_wr = merge({17'h00000, trim_r}, wdata_r, wstrb_r);

    always_comb
    begin
        wr_val = merge(32'h00000000, wdata_r, wstrb_r);
        wr_ok = 1'b1;
        unique case (awaddr_r)
            OFF_MATCH_ZERO, OFF_MATCH_ONE, OFF_LOAD, OFF_CONTROL, OFF_MASK, OFF_CLEAR,
            OFF_TRIM, OFF_COUNTER, OFF_RAW, OFF_MASKED: wr_ok = 1'b1;
            default: wr_ok = wr_mem;
        endcase
        // Unaligned addresses are refused too
        if (awaddr_r[1:0] != 2'h0)
        begin
            wr_ok = 1'b0;
        end
    end

    always_comb
    begin
        rd_val = 32'h00000000;
        rd_ok = 1'b1;
        unique case (S_AXI_ARADDR)
            OFF_COUNTER: rd_val = counter_r;
            OFF_MATCH_ZERO: rd_val = match_zero_r;
            OFF_MATCH_ONE: rd_val = match_one_r;
            OFF_LOAD: rd_val = load_r;
            OFF_CONTROL: rd_val = {24'h000000, control_r};
            OFF_MASK: rd_val = {28'h0000000, mask_r};
            OFF_RAW: rd_val = {28'h0000000, raw_r};
            OFF_MASKED: rd_val = {28'h0000000, raw_r & mask_r};
            OFF_CLEAR: rd_val = 32'h00000000;
            OFF_TRIM: rd_val = {17'h00000, trim_r};
            default:
            begin
                if ((S_AXI_ARADDR >= OFF_MEM_LO) && (S_AXI_ARADDR <= OFF_MEM_HI))
                begin
                    rd_val = mem_r[mem_ridx];
                end
                else
                begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        if (S_AXI_ARADDR[1:0] != 2'h0)
        begin
            rd_ok = 1'b0;
            rd_val = 32'h00000000;
        end
    end

    always_comb
    begin
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        arready_nxt = 1'b0;
        if (S_AXI_AWVALID && !aw_have_r)
        begin
            awaddr_nxt = S_AXI_AWADDR;
            aw_have_nxt = 1'b1;
        end
        if (S_AXI_WVALID && !w_have_r)
        begin
            wdata_nxt = S_AXI_WDATA;
            wstrb_nxt = S_AXI_WSTRB;
            w_have_nxt = 1'b1;
        end
        if (wr_go)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_r && S_AXI_BREADY)
        begin
            bvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID && !rvalid_r && !arready_r)
        begin
            arready_nxt = 1'b1;
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_val;
            rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_r && S_AXI_RREADY)
        begin
            rvalid_nxt = 1'b0;
        end
        // Ready lines come from flops, so they follow the next held flags
        awready_nxt = ~aw_have_nxt;
        wready_nxt = ~w_have_nxt;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
            arready_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else if (CLK_EN)
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            arready_r <= arready_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference tick, predivider and counter
    logic ref_tick;
    logic second_pulse;
    logic match_zero_hit;
    logic match_one_hit;
    logic wake_event;
    logic [EV_BITS-1:0] set_ev;
    logic [EV_BITS-1:0] clr_ev;
    logic sleeping;

    always_comb
    begin
        xtal_div_nxt = xtal_div_r;
        ref_tick = 1'b0;
        if (control_r[CTL_REFERENCE_CLOCK_ENABLE] && ref_rise)
        begin
            if (control_r[CTL_REFERENCE_SELECT])
            begin
                ref_tick = 1'b1;
            end
            else
            begin
                // Crystal edges divided by 128; the system clock must outrun them
                xtal_div_nxt = xtal_div_r + 7'h01;
                ref_tick = (xtal_div_r == CRYSTAL_DIVIDE_LAST);
            end
        end
    end

    always_comb
    begin
        prediv_nxt = prediv_r;
        second_idx_nxt = second_idx_r;
        second_pulse = 1'b0;
        if (control_r[CTL_COUNTER_ENABLE] && ref_tick)
        begin
            if (prediv_r == 15'h0000)
            begin
                second_pulse = 1'b1;
                second_idx_nxt = second_idx_r + 6'h01;
                // Trimmed count once in 64 seconds, nominal otherwise
                prediv_nxt = NOMINAL_DIVIDE;
                if (second_idx_nxt == TRIM_PERIOD_LAST)
                begin
                    // Larger trim gives a longer second, smaller a shorter one
                    prediv_nxt = trim_r;
                end
            end
            else
            begin
                prediv_nxt = prediv_r - 15'h0001;
            end
        end
    end

    assign match_zero_hit = control_r[CTL_COUNTER_ENABLE]
        && (counter_r == match_zero_r);
    assign match_one_hit = control_r[CTL_COUNTER_ENABLE]
        && (counter_r == match_one_r);
    assign sleeping = ~regulator_off_n_r;

    always_comb
    begin
        counter_nxt = counter_r;
        match_zero_nxt = match_zero_r;
        match_one_nxt = match_one_r;
        load_nxt = load_r;
        control_nxt = control_r;
        mask_nxt = mask_r;
        trim_nxt = trim_r;
        clr_ev = '0;
        // Counting carries on through sleep; no power gating is modelled here
        if (second_pulse)
        begin
            counter_nxt = counter_r + 32'h00000001;
        end
        if (wr_go && wr_ok)
        begin
            unique case (awaddr_r)
                OFF_MATCH_ZERO: match_zero_nxt = merge(match_zero_r, wdata_r, wstrb_r);
                OFF_MATCH_ONE: match_one_nxt = merge(match_one_r, wdata_r, wstrb_r);
                OFF_LOAD:
                begin
                    load_nxt = merge(load_r, wdata_r, wstrb_r);
                    counter_nxt = load_nxt;
                end
                OFF_CONTROL: control_nxt = ctl_wr[7:0];
                OFF_MASK: mask_nxt = mask_wr[EV_BITS-1:0];
                OFF_CLEAR: clr_ev = wr_val[EV_BITS-1:0];
                OFF_TRIM: trim_nxt = trim_wr[14:0];
                default: clr_ev = '0;
            endcase
        end
        // Request bit is a one-shot command
        if (control_r[CTL_SLEEP_REQUEST])
        begin
            control_nxt[CTL_SLEEP_REQUEST] = 1'b0;
        end
    end

    always_comb
    begin
        set_ev = '0;
        set_ev[EV_MATCH_ZERO] = match_zero_hit;
        set_ev[EV_MATCH_ONE] = match_one_hit;
        // Battery is not judged in sleep, when the main supply is off
        set_ev[EV_LOW_BATTERY] = control_r[CTL_LOW_BATTERY_DETECT_ENABLE]
            & low_batt & ~sleeping;
        set_ev[EV_WAKE_PIN] = wake_pin;
        // A new event outranks a clear in the same cycle
        raw_nxt = (raw_r & ~clr_ev) | set_ev;
        irq_nxt = |(raw_nxt & mask_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep sequence
    always_comb
    begin
        wake_event = (control_r[CTL_PIN_WAKE_ENABLE] & wake_pin)
            | (control_r[CTL_MATCH_WAKE_ENABLE] & (match_zero_hit | match_one_hit));
        regulator_off_n_nxt = regulator_off_n_r;
        wake_reset_nxt = 1'b0;
        if (sleeping)
        begin
            if (wake_event)
            begin
                regulator_off_n_nxt = 1'b1;
                wake_reset_nxt = 1'b1;
            end
        end
        else if (control_r[CTL_SLEEP_REQUEST]
                 && (control_r[CTL_PIN_WAKE_ENABLE] || control_r[CTL_MATCH_WAKE_ENABLE])
                 && !(control_r[CTL_LOW_BATTERY_ABORT] && control_r[CTL_LOW_BATTERY_DETECT_ENABLE]
                      && low_batt))
        begin
            regulator_off_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        // Unknown control at power-up lands in the reset branch, as a cold start
        if (!do_reset)
        begin
            if (CLK_EN)
            begin
                counter_r <= counter_nxt;
                match_zero_r <= match_zero_nxt;
                match_one_r <= match_one_nxt;
                load_r <= load_nxt;
                control_r <= control_nxt;
                mask_r <= mask_nxt;
                raw_r <= raw_nxt;
                trim_r <= trim_nxt;
                prediv_r <= prediv_nxt;
                second_idx_r <= second_idx_nxt;
                xtal_div_r <= xtal_div_nxt;
                regulator_off_n_r <= regulator_off_n_nxt;
                wake_reset_r <= wake_reset_nxt;
                irq_r <= irq_nxt;
            end
        end
        else
        begin
            counter_r <= 32'h00000000;
            match_zero_r <= RST_MATCH;
            match_one_r <= RST_MATCH;
            load_r <= RST_LOAD;
            control_r <= RST_CONTROL;
            mask_r <= '0;
            raw_r <= '0;
            trim_r <= RST_TRIM;
            prediv_r <= RST_TRIM;
            second_idx_r <= 6'h00;
            xtal_div_r <= 7'h00;
            regulator_off_n_r <= 1'b1;
            wake_reset_r <= 1'b0;
            irq_r <= 1'b0;
        end
    end

    // Retained memory has no reset so contents survive any reset
    always_ff @(posedge SYS_CLK)
    begin
        if (CLK_EN && wr_mem && wr_ok)
        begin
            mem_r[mem_widx] <= merge(mem_r[mem_widx], wdata_r, wstrb_r);
        end
    end

    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign REGULATOR_OFF_N = regulator_off_n_r;
    assign WAKE_RESET = wake_reset_r;
    assign IRQ = irq_r;

endmodule
`default_nettype wire

// ---- verif/far_side_model.sv ----
// Regulator, wake pin and reference oscillator around the sleep block
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
    input wire logic REGULATOR_OFF_N,
    input wire logic wake_req,
    input wire logic bat_low,
    output logic REF_CLK_IN,
    output logic WAKE_N,
    output logic LOW_BATTERY,
    output logic powered
);
    initial REF_CLK_IN = 1'b0;
    // Scaled reference; a true second would blow the run budget
    always #400 REF_CLK_IN = ~REF_CLK_IN;
    // Pull-up keeps the pin high unless pressed
    assign WAKE_N = ~wake_req;
    assign LOW_BATTERY = bat_low;
    assign powered = REGULATOR_OFF_N;
endmodule
`default_nettype wire

// ---- verif/sleep_rtc_checker.sv ----
// Bus and wake timing checks on the sleep block ports
`timescale 1ns/10ps
`default_nettype none
module sleep_rtc_checker (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic REGULATOR_OFF_N,
    input wire logic WAKE_RESET
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_ar_pulse;
        S_AXI_ARREADY |=> !S_AXI_ARREADY;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("read accept too long");
    property p_ar_with_r;
        S_AXI_ARREADY |-> S_AXI_RVALID;
    endproperty
    a_ar_with_r: assert property (p_ar_with_r) else $error("accept without data");
    property p_w_answer;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID;
    endproperty
    a_w_answer: assert property (p_w_answer) else $error("write never answered");
    property p_r_answer;
        S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID |-> ##[1:2] S_AXI_RVALID;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read never answered");
    property p_wake_pulse;
        WAKE_RESET |=> !WAKE_RESET;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake reset too long");
    property p_wake_power;
        WAKE_RESET |-> ##[0:1] REGULATOR_OFF_N;
    endproperty
    a_wake_power: assert property (p_wake_power) else $error("power not restored");
endmodule
bind sleep_rtc_ctl sleep_rtc_checker chk_i (.SYS_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .REGULATOR_OFF_N, .WAKE_RESET);
`default_nettype wire

// ---- verif/tb_sleep_rtc_ctl.sv ----
// Self-checking bench for the sleep and seconds-counter block
`timescale 1ns/10ps
`default_nettype none
module tb_sleep_rtc_ctl
    import sleep_ctl_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wake_req = 1'b0, bat_low = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ref_clk, wake_n, low_bat, reg_n, wrst, irq;
    logic [1:0] bresp, rresp, rs;
    int fails = 0, cmp_count = 0;
    // Crystal settle wait in system clocks; the value is arbitrary
    localparam int SETTLE_CYCLES = 20;
    logic [11:0] roff [8] = '{OFF_COUNTER, OFF_MATCH_ZERO, OFF_MATCH_ONE, OFF_LOAD,
        OFF_CONTROL, OFF_MASK, OFF_RAW, OFF_TRIM};
    logic [31:0] rexp [8] = '{32'h0, RST_MATCH, RST_MATCH, RST_LOAD, 32'h0, 32'h0, 32'h0,
        32'h7fff};
    logic [11:0] woff [4] = '{OFF_MATCH_ZERO, OFF_MATCH_ONE, OFF_TRIM, OFF_MASK};
    logic [31:0] wval [4] = '{32'h10, 32'ha5a50001, 32'h7ffe, 32'h3};
    logic [31:0] cv [2] = '{32'h4f, 32'h5f};
    sleep_rtc_ctl uut (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .REF_CLK_IN(ref_clk),
        .WAKE_N(wake_n), .LOW_BATTERY(low_bat), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .REGULATOR_OFF_N(reg_n), .WAKE_RESET(wrst), .IRQ(irq));
    far_side_model peer (.REGULATOR_OFF_N(reg_n), .wake_req(wake_req), .bat_low(bat_low),
        .REF_CLK_IN(ref_clk), .WAKE_N(wake_n), .LOW_BATTERY(low_bat), .powered());
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 50)
        begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        hang(n);
        @(posedge clk);
    endtask
    task automatic axr(input logic [11:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        hang(n);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        axr(a);
        chk(rd, exp);
    endtask
    // Bounded wait: 0 watches the regulator line, 1 the wake reset pulse
    task automatic wait_for(input int which, input logic val);
        int n;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if ((which == 0 ? reg_n : wrst) === val) break;
        end
        cmp_count++;
        hang(n);
    endtask
    task automatic reset_pulse();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_pulse();
        for (int i = 0; i < 8; i++) rchk(roff[i], rexp[i]);
        axw(OFF_CONTROL, 32'h40);
        repeat (SETTLE_CYCLES) @(posedge clk);
        rchk(OFF_CONTROL, 32'h40);
        axw(OFF_CONTROL, 32'h44);
        rchk(OFF_CONTROL, 32'h44);
        for (int i = 0; i < 4; i++)
        begin
            axw(woff[i], wval[i]);
            rchk(woff[i], wval[i]);
        end
        axw(OFF_LOAD, 32'h10);
        rchk(OFF_COUNTER, 32'h10);
        axw(OFF_CONTROL, 32'h41);
        rchk(OFF_RAW, 32'h1);
        rchk(OFF_MASKED, 32'h1);
        chk(irq, 1'b1);
        axw(OFF_MATCH_ZERO, 32'h20);
        axw(OFF_CLEAR, 32'h1);
        rchk(OFF_RAW, 32'h0);
        chk(irq, 1'b0);
        axw(OFF_MEM_LO, 32'hc0de0001);
        axw(OFF_MEM_HI, 32'h5a5a0002);
        rchk(OFF_MEM_LO, 32'hc0de0001);
        rchk(OFF_MEM_HI, 32'h5a5a0002);
        axw(12'h028, 32'h1);
        chk(rs, RESP_SLVERR);
        rchk(12'h028, 32'h0);
        chk(rs, RESP_SLVERR);
        axw(OFF_MASK, 32'h8);
        axw(OFF_CONTROL, 32'h56);
        wait_for(0, 1'b0);
        wake_req <= 1'b1;
        wait_for(1, 1'b1);
        wait_for(0, 1'b1);
        wake_req <= 1'b0;
        rchk(OFF_RAW, 32'h8);
        rchk(OFF_MASKED, 32'h8);
        chk(irq, 1'b1);
        axr(OFF_CONTROL);
        chk(rd & 32'h42, 32'h40);
        axw(OFF_CLEAR, 32'h8);
        rchk(OFF_RAW, 32'h0);
        axw(OFF_MATCH_ZERO, 32'h10);
        for (int i = 0; i < 2; i++)
        begin
            axw(OFF_CONTROL, cv[i]);
            wait_for(1, 1'b1);
        end
        axw(OFF_MATCH_ZERO, 32'h20);
        axw(OFF_CLEAR, 32'hf);
        bat_low <= 1'b1;
        axw(OFF_CONTROL, 32'hf6);
        repeat (20) @(posedge clk);
        chk(reg_n, 1'b1);
        rchk(OFF_RAW, 32'h4);
        rchk(OFF_MASKED, 32'h0);
        bat_low <= 1'b0;
        axw(OFF_CONTROL, 32'h41);
        reset_pulse();
        rchk(OFF_MATCH_ZERO, 32'h20);
        axw(OFF_CONTROL, 32'h0);
        reset_pulse();
        rchk(OFF_MATCH_ZERO, RST_MATCH);
        give_verdict();
    end
endmodule
`default_nettype wire
